// ==== design/pie_irq_bank.v ====
`timescale 1ns/10ps
`include "pie_defines.vh"

module pie_irq_bank (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // peripheral flags, groups a,b,c in bits 7..0, 15..8, 23..16
  input  wire [23:0] flag_i,
  input  wire        mcu_mode_i,
  // requests toward the core
  output reg         irq_req_o,
  output reg         irq_high_o,
  output reg         irq_low_o
);

  // ----------------------------------------
  // sizes and source positions
  // ----------------------------------------
  // one byte register per 32-bit word, low byte only; the upper bytes read
  // zero so software may use word or byte loads alike
  // flat source vector: group a in 7..0, group b in 15..8, group c in 23..16
  localparam NUM_SRC              = 24;

  // group a, all eight positions in use
  localparam SRC_TIMER1_OVF       = 0;
  localparam SRC_TIMER2_MATCH     = 1;
  localparam SRC_CAPCMP1          = 2;
  localparam SRC_SYNC_SERIAL      = 3;
  localparam SRC_UART1_TX         = 4;
  localparam SRC_UART1_RX         = 5;
  localparam SRC_ADC_DONE         = 6;
  localparam SRC_SLAVE_PORT       = `PIE_SLAVE_PORT_BIT;

  // group b, bits 15 and 13 are holes
  localparam SRC_CAPCMP2          = 8;
  localparam SRC_TIMER3_OVF       = 9;
  localparam SRC_LOW_VOLTAGE      = 10;
  localparam SRC_BUS_COLLISION    = 11;
  localparam SRC_NVM_WRITE        = 12;
  localparam SRC_COMPARATOR       = 14;

  // group c, bits 23 and 22 are holes; capture units 3..5 share one field
  localparam SRC_CAPCMP3TO5_LO    = 16;
  localparam SRC_CAPCMP3TO5_HI    = 18;
  localparam SRC_TIMER4_MATCH     = 19;
  localparam SRC_UART2_TX         = 20;
  localparam SRC_UART2_RX         = 21;

  // per source gating nets
  genvar      src_idx;
  wire [23:0] src_gate;
  wire [23:0] pend_high;
  wire [23:0] pend_low;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg  [23:0] enable_q;
  reg  [23:0] prio_q;
  reg  [1:0]  ctl_q;
  wire [23:0] mask;
  wire [23:0] eff_en;
  wire [23:0] eff_prio;
  wire [23:0] pending;
  wire        prio_mode;
  wire        global_en;
  wire        req_d;
  wire        high_d;
  wire        low_d;
  wire        acc;
  reg  [7:0]  rd_byte;

  // ----------------------------------------
  // named register views
  // ----------------------------------------
  // named bits keep the read map readable and make a misplaced bit obvious

  wire       slave_port_access_irq_en   = enable_q[SRC_SLAVE_PORT];
  wire       adc_done_irq_en            = enable_q[SRC_ADC_DONE];
  wire       uart1_rx_irq_en            = enable_q[SRC_UART1_RX];
  wire       uart1_tx_irq_en            = enable_q[SRC_UART1_TX];
  wire       sync_serial_irq_en         = enable_q[SRC_SYNC_SERIAL];
  wire       capcmp1_irq_en             = enable_q[SRC_CAPCMP1];
  wire       timer2_match_irq_en        = enable_q[SRC_TIMER2_MATCH];
  wire       timer1_overflow_irq_en     = enable_q[SRC_TIMER1_OVF];

  wire       comparator_irq_en          = enable_q[SRC_COMPARATOR];
  wire       nvm_write_irq_en           = enable_q[SRC_NVM_WRITE];
  wire       bus_collision_irq_en       = enable_q[SRC_BUS_COLLISION];
  wire       low_voltage_irq_en         = enable_q[SRC_LOW_VOLTAGE];
  wire       timer3_overflow_irq_en     = enable_q[SRC_TIMER3_OVF];
  wire       capcmp2_irq_en             = enable_q[SRC_CAPCMP2];

  wire       uart2_rx_irq_en            = enable_q[SRC_UART2_RX];
  wire       uart2_tx_irq_en            = enable_q[SRC_UART2_TX];
  wire       timer4_match_irq_en        = enable_q[SRC_TIMER4_MATCH];
  wire [2:0] capcmp3to5_irq_en          = enable_q[SRC_CAPCMP3TO5_HI:SRC_CAPCMP3TO5_LO];

  wire       slave_port_access_irq_prio = prio_q[SRC_SLAVE_PORT];
  wire       adc_done_irq_prio          = prio_q[SRC_ADC_DONE];
  wire       uart1_rx_irq_prio          = prio_q[SRC_UART1_RX];
  wire       uart1_tx_irq_prio          = prio_q[SRC_UART1_TX];
  wire       sync_serial_irq_prio       = prio_q[SRC_SYNC_SERIAL];
  wire       capcmp1_irq_prio           = prio_q[SRC_CAPCMP1];
  wire       timer2_match_irq_prio      = prio_q[SRC_TIMER2_MATCH];
  wire       timer1_overflow_irq_prio   = prio_q[SRC_TIMER1_OVF];

  wire       comparator_irq_prio        = prio_q[SRC_COMPARATOR];
  wire       nvm_write_irq_prio         = prio_q[SRC_NVM_WRITE];
  wire       bus_collision_irq_prio     = prio_q[SRC_BUS_COLLISION];
  wire       low_voltage_irq_prio       = prio_q[SRC_LOW_VOLTAGE];
  wire       timer3_overflow_irq_prio   = prio_q[SRC_TIMER3_OVF];
  wire       capcmp2_irq_prio           = prio_q[SRC_CAPCMP2];

  wire       uart2_rx_irq_prio          = prio_q[SRC_UART2_RX];
  wire       uart2_tx_irq_prio          = prio_q[SRC_UART2_TX];
  wire       timer4_match_irq_prio      = prio_q[SRC_TIMER4_MATCH];
  wire [2:0] capcmp3to5_irq_prio        = prio_q[SRC_CAPCMP3TO5_HI:SRC_CAPCMP3TO5_LO];

  // read bytes, holes forced to zero whatever the stored bit holds
  wire [7:0] view_en_a;
  wire [7:0] view_en_b;
  wire [7:0] view_en_c;
  wire [7:0] view_prio_a;
  wire [7:0] view_prio_b;
  wire [7:0] view_prio_c;

  assign view_en_a   = {slave_port_access_irq_en, adc_done_irq_en, uart1_rx_irq_en,
                        uart1_tx_irq_en, sync_serial_irq_en, capcmp1_irq_en,
                        timer2_match_irq_en, timer1_overflow_irq_en};
  assign view_en_b   = {1'h0, comparator_irq_en, 1'h0, nvm_write_irq_en,
                        bus_collision_irq_en, low_voltage_irq_en,
                        timer3_overflow_irq_en, capcmp2_irq_en};
  assign view_en_c   = {2'h0, uart2_rx_irq_en, uart2_tx_irq_en,
                        timer4_match_irq_en, capcmp3to5_irq_en};
  assign view_prio_a = {slave_port_access_irq_prio, adc_done_irq_prio, uart1_rx_irq_prio,
                        uart1_tx_irq_prio, sync_serial_irq_prio, capcmp1_irq_prio,
                        timer2_match_irq_prio, timer1_overflow_irq_prio};
  assign view_prio_b = {1'h0, comparator_irq_prio, 1'h0, nvm_write_irq_prio,
                        bus_collision_irq_prio, low_voltage_irq_prio,
                        timer3_overflow_irq_prio, capcmp2_irq_prio};
  assign view_prio_c = {2'h0, uart2_rx_irq_prio, uart2_tx_irq_prio,
                        timer4_match_irq_prio, capcmp3to5_irq_prio};

  assign mask = {`PIE_MASK_C, `PIE_MASK_B, `PIE_MASK_A};
  assign prio_mode = ctl_q[`PIE_CTL_PRIO_BIT];
  assign global_en = ctl_q[`PIE_CTL_GLOBAL_BIT];
  // single cycle ack: the request is taken only while ack is low
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // unimplemented bits are masked so they always read zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= {`PIE_EN_RESET, `PIE_EN_RESET, `PIE_EN_RESET};
      prio_q   <= {`PIE_PRIO_RESET_C, `PIE_PRIO_RESET_B, `PIE_PRIO_RESET_A};
      ctl_q    <= `PIE_CTL_RESET;
    end else if (acc && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        `PIE_ADDR_ENABLE_A:   enable_q[7:0]   <= wb_dat_i[7:0] & `PIE_MASK_A;
        `PIE_ADDR_ENABLE_B:   enable_q[15:8]  <= wb_dat_i[7:0] & `PIE_MASK_B;
        `PIE_ADDR_ENABLE_C:   enable_q[23:16] <= wb_dat_i[7:0] & `PIE_MASK_C;
        `PIE_ADDR_PRIORITY_A: prio_q[7:0]     <= wb_dat_i[7:0] & `PIE_MASK_A;
        `PIE_ADDR_PRIORITY_B: prio_q[15:8]    <= wb_dat_i[7:0] & `PIE_MASK_B;
        `PIE_ADDR_PRIORITY_C: prio_q[23:16]   <= wb_dat_i[7:0] & `PIE_MASK_C;
        `PIE_ADDR_CONTROL:    ctl_q           <= wb_dat_i[1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // request logic
  // ----------------------------------------
  // one slice per source; every position is handled the same way except the slave port, which adds the mode gate
  generate
    for (src_idx = 0; src_idx < NUM_SRC; src_idx = src_idx + 1) begin : g_src
      if (src_idx == SRC_SLAVE_PORT) begin : g_mode
        // outside microcontroller mode the slave port source is dead
        assign src_gate[src_idx] = mcu_mode_i;
      end else begin : g_plain
        assign src_gate[src_idx] = 1'h1;
      end
      // holes are masked even if a stray flag shows up there
      assign eff_en[src_idx]    = enable_q[src_idx] & mask[src_idx] & src_gate[src_idx];
      assign eff_prio[src_idx]  = prio_q[src_idx] & mask[src_idx];
      assign pending[src_idx]   = flag_i[src_idx] & eff_en[src_idx];
      assign pend_high[src_idx] = pending[src_idx] & eff_prio[src_idx];
      assign pend_low[src_idx]  = pending[src_idx] & ~eff_prio[src_idx];
    end
  endgenerate

  assign req_d    = prio_mode ? (|pending) : (global_en & (|pending));
  // priority routing only in priority mode
  assign high_d   = prio_mode & (|pend_high);
  assign low_d    = prio_mode & (|pend_low);

  // mcu_mode_i is a static strap from the same clock domain
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_o  <= 1'b0;
      irq_high_o <= 1'b0;
      irq_low_o  <= 1'b0;
    end else begin
      irq_req_o  <= req_d;
      irq_high_o <= high_d;
      irq_low_o  <= low_d;
    end
  end

  // ----------------------------------------
  // read mux and ack
  // ----------------------------------------
  // unmapped addresses read zero and still ack, so the bus never hangs
  always @* begin
    rd_byte = 8'h00;
    case (wb_adr_i)
      `PIE_ADDR_ENABLE_A:   rd_byte = view_en_a;
      `PIE_ADDR_ENABLE_B:   rd_byte = view_en_b;
      `PIE_ADDR_ENABLE_C:   rd_byte = view_en_c;
      `PIE_ADDR_PRIORITY_A: rd_byte = view_prio_a;
      `PIE_ADDR_PRIORITY_B: rd_byte = view_prio_b;
      `PIE_ADDR_PRIORITY_C: rd_byte = view_prio_c;
      `PIE_ADDR_CONTROL:    rd_byte = {6'h00, ctl_q};
      `PIE_ADDR_STATUS:     rd_byte = {5'h00, irq_low_o, irq_high_o, irq_req_o};
      default:              rd_byte = 8'h00;
    endcase
  end

  // ack follows the taking edge by exactly one cycle and lasts one cycle;
  // masking the request with ack stops a held strobe from being taken on
  // back-to-back edges, but it is taken again after the ack, so the master must drop cyc and stb after each answer
  // read data is zero outside ack, which keeps a shared return bus quiet
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

endmodule

// ==== design/pie_defines.vh ====
`ifndef PIE_DEFINES_VH
`define PIE_DEFINES_VH
// ----------------------------------------
// register byte addresses (word aligned)
// ----------------------------------------
`define PIE_ADDR_ENABLE_A    6'h00
`define PIE_ADDR_ENABLE_B    6'h04
`define PIE_ADDR_ENABLE_C    6'h08
`define PIE_ADDR_PRIORITY_A  6'h0C
`define PIE_ADDR_PRIORITY_B  6'h10
`define PIE_ADDR_PRIORITY_C  6'h14
`define PIE_ADDR_CONTROL     6'h18
`define PIE_ADDR_STATUS      6'h1C
// ----------------------------------------
// implemented bit masks and reset values
// ----------------------------------------
`define PIE_MASK_A           8'hFF
`define PIE_MASK_B           8'h5F
`define PIE_MASK_C           8'h3F
`define PIE_EN_RESET         8'h00
`define PIE_PRIO_RESET_A     8'hFF
`define PIE_PRIO_RESET_B     8'h5F
`define PIE_PRIO_RESET_C     8'h3F
// ----------------------------------------
// control register fields
// ----------------------------------------
`define PIE_CTL_PRIO_BIT     0
`define PIE_CTL_GLOBAL_BIT   1
`define PIE_CTL_RESET        2'h0
// slave port source is bit 7 of group a
`define PIE_SLAVE_PORT_BIT   7
`endif

// ==== verif/pie_periph_model.sv ====
`timescale 1ns/10ps
// flag sources: registered, as real source flops would be
module pie_periph_model (
  input  wire         clk_i,
  input  wire  [23:0] set_i,
  output logic [23:0] flag_o = 24'h0
);
  always @(posedge clk_i) flag_o <= set_i;
endmodule

// ==== verif/pie_irq_bank_properties.sv ====
`timescale 1ns/10ps
// port-side watcher of bus answers and request lines
module pie_irq_bank_properties (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire        wb_ack_o,
  input wire        mcu_mode_i,
  input wire        irq_req_o,
  input wire        irq_high_o,
  input wire        irq_low_o,
  input wire [31:0] wb_dat_o,
  input wire [23:0] flag_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_one: assert property (p_one) else $error("long ack");
  property p_dz; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dz: assert property (p_dz) else $error("idle data");
  property p_top; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_top: assert property (p_top) else $error("upper bits");
  property p_sub; irq_high_o || irq_low_o |-> irq_req_o; endproperty
  a_sub: assert property (p_sub) else $error("level alone");
  property p_unimp; (flag_i & 24'h3F5FFF) == 24'h0 |=> !irq_req_o; endproperty
  a_unimp: assert property (p_unimp) else $error("masked flag");
  property p_mcu; !mcu_mode_i && (flag_i & 24'h3F5F7F) == 24'h0 |=> !irq_req_o; endproperty
  a_mcu: assert property (p_mcu) else $error("slave port");
  // outputs may only move when flags, mode or registers moved
  property p_hold; $stable(flag_i) && $stable(mcu_mode_i) && !$past(wb_stb_i && wb_we_i)
    |=> $stable({irq_req_o, irq_high_o, irq_low_o}); endproperty
  a_hold: assert property (p_hold) else $error("spurious change");
  c_high: cover property (irq_high_o);
  c_low: cover property (irq_low_o);
  c_wr: cover property (wb_ack_o && wb_we_i);
endmodule
bind pie_irq_bank pie_irq_bank_properties pie_irq_bank_properties_inst (
  .clk_i      (clk_i),
  .rst_i      (rst_i),
  .wb_cyc_i   (wb_cyc_i),
  .wb_stb_i   (wb_stb_i),
  .wb_we_i    (wb_we_i),
  .wb_ack_o   (wb_ack_o),
  .mcu_mode_i (mcu_mode_i),
  .irq_req_o  (irq_req_o),
  .irq_high_o (irq_high_o),
  .irq_low_o  (irq_low_o),
  .wb_dat_o   (wb_dat_o),
  .flag_i     (flag_i)
);

// ==== verif/pie_irq_bank_tb_top.sv ====
`timescale 1ns/10ps
module pie_irq_bank_tb_top;
  logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, mcu = 0;
  logic [3:0]  sel = 4'h0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] di = 32'h0, r;
  logic [23:0] fset = 24'h0, pd;
  logic [2:0]  ex;
  logic [7:0]  lf = 8'h52, d, m [0:7], mk [0:7];
  wire  [31:0] dout;
  wire  [23:0] flag;
  wire         ack, rq, hi, lo;
  int          num_errors = 0, n_tests = 0;
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  pie_periph_model pie_periph_model_inst (.clk_i(clk_i), .set_i(fset), .flag_o(flag));
  pie_irq_bank pie_irq_bank_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dout),
    .wb_ack_o(ack), .flag_i(flag), .mcu_mode_i(mcu), .irq_req_o(rq), .irq_high_o(hi),
    .irq_low_o(lo));
  function automatic logic [7:0] nx();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  // one classic cycle; the reference copy updates only on a real write
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] v, input logic [3:0] s);
    @(posedge clk_i);
    {cyc, we, adr, di, sel} <= {1'b1, w, a, 24'h0, v, s};
    // this wait ends when ack is seen high; only the watchdog ends it if ack never comes
    do @(posedge clk_i); while (ack !== 1'b1);
    r = dout;
    if (w && s[0] && a < 6'h1C) m[a[4:2]] = v & mk[a[4:2]];
    {cyc, we} <= 2'b00;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    num_errors += (g !== e);
    if (g !== e) $display("BAD t=%0t got=%h exp=%h", $time, g, e);
  endtask
  task give_verdict;
    $display("errors=%0d tests=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog, well beyond the expected run
  initial begin
    #100000 num_errors++;
    give_verdict();
  end
  initial begin
    m = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h5F, 8'h3F, 8'h00, 8'h00};
    mk = '{8'hFF, 8'h5F, 8'h3F, 8'hFF, 8'h5F, 8'h3F, 8'h03, 8'h00};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, status and the unmapped word above the map
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, 6'(i * 4), 8'h00, 4'hF);
      cmp(r, {24'h0, i < 7 ? m[i] : 8'h00});
    end
    // first two passes aim the slave port gate, the rest are random
    for (int n = 0; n < 40; n++) begin
      for (int i = 0; i < 9; i++) begin
        d = n < 2 ? 8'hFF : nx();
        bus(1'b1, 6'(i * 4), d, n % 5 == 4 ? 4'hE : 4'hF);
      end
      @(posedge clk_i);
      fset <= n < 2 ? 24'hC0A080 : {nx(), nx(), nx()};
      mcu <= n[0];
      repeat (3) @(posedge clk_i);
      pd = fset & {m[2], m[1], m[0]} & {16'hFFFF, mcu, 7'h7F};
      ex = {m[6][0] ? |pd : m[6][1] & |pd, m[6][0] & |(pd & {m[5], m[4], m[3]}),
        m[6][0] & |(pd & ~{m[5], m[4], m[3]})};
      cmp({29'h0, rq, hi, lo}, {29'h0, ex});
      // registers, then the status word with the expected request levels
      for (int i = 0; i < 8; i++) begin
        bus(1'b0, 6'(i * 4), 8'h00, 4'hF);
        cmp(r, {24'h0, i < 7 ? m[i] : {5'h00, ex[0], ex[1], ex[2]}});
      end
    end
    give_verdict();
  end
endmodule
